/* File: rtl/ocfg_pkg.sv */
// shared constants, register map and mode type for the output macrocell array
package ocfg_pkg;

  localparam int NUM_CELLS   = 8;
  localparam int PT_PER_CELL = 8;
  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 32;

  // cell positions: outermost pair and innermost pair
  localparam int OUTER_LO = 0;
  localparam int OUTER_HI = 7;
  localparam int INNER_LO = 3;
  localparam int INNER_HI = 4;

  // product term that serves as a cell's own output enable
  localparam int OE_TERM_IDX = 0;

  localparam logic [ADDR_W-1:0] ADDR_MODE   = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_POL    = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_IOCFG  = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_RUN    = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_PINS   = 12'h014;

  localparam int MODE_SYNC_POS = 0;
  localparam int MODE_ARCH_POS = 1;
  localparam int MODE_EFF_POS  = 4;
  localparam int RUN_POS       = 0;
  localparam int ST_REG_POS    = 0;
  localparam int ST_DRV_POS    = 8;
  localparam int ST_IN_POS     = 16;
  localparam int ST_MODE_POS   = 24;
  localparam int PINS_SPEC_POS = 8;

  localparam logic                 SYNC_RST  = 1'b1;
  localparam logic                 ARCH_RST  = 1'b0;
  localparam logic [NUM_CELLS-1:0] POL_RST   = 8'h00;
  localparam logic [NUM_CELLS-1:0] IOCFG_RST = 8'hff;
  localparam logic                 RUN_RST   = 1'b0;

  typedef enum logic [1:0] {
    MODE_REG     = 2'b00,
    MODE_COMPLEX = 2'b01,
    MODE_SIMPLE  = 2'b10,
    MODE_BAD     = 2'b11
  } mode_t;

  function automatic mode_t decode_mode(input logic sync_bit, input logic arch_bit);
    case ({sync_bit, arch_bit})
      2'b10:   decode_mode = MODE_SIMPLE;
      2'b11:   decode_mode = MODE_COMPLEX;
      2'b01:   decode_mode = MODE_REG;
      default: decode_mode = MODE_BAD;
    endcase
  endfunction : decode_mode

endpackage : ocfg_pkg

/* File: rtl/output_macrocell.sv */
// one output macrocell: term summing, register, polarity and output enable
`timescale 1ns/100ps
module output_macrocell #(
  parameter int PT_W     = ocfg_pkg::PT_PER_CELL,
  parameter bit IS_OUTER = 1'b0,
  parameter bit IS_INNER = 1'b0
) (
  input  wire logic            ref_clk,
  input  wire logic            rst_b,
  input  wire ocfg_pkg::mode_t mode,
  input  wire logic            run,
  input  wire logic            io_cfg,
  input  wire logic            polarity,
  input  wire logic [PT_W-1:0] pt,
  input  wire logic            clk_edge,
  input  wire logic            shared_oe,
  output logic                 pin_out,
  output logic                 pin_oe_b,
  output logic                 reg_q_o,
  output logic                 is_input
);
  import ocfg_pkg::*;

  logic sum_all;
  logic sum_less;
  logic oe_term;
  logic reg_bit_q;
  logic val;
  logic drive;
  logic as_input;

  assign sum_all  = |pt;
  assign sum_less = |pt[PT_W-1:OE_TERM_IDX+1];
  assign oe_term  = pt[OE_TERM_IDX];
  assign reg_q_o  = reg_bit_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_bit_q <= 1'b0;
    end else if (run && mode == MODE_REG && !io_cfg && clk_edge) begin
      reg_bit_q <= sum_all;
    end
  end

  always_comb begin
    val      = 1'b0;
    drive    = 1'b0;
    as_input = 1'b0;
    case (mode)
      MODE_REG: begin
        if (!io_cfg) begin
          val   = reg_bit_q;
          drive = shared_oe;
        end else begin
          // a dedicated input is this with oe term low, an output with it high
          val      = sum_less;
          drive    = oe_term;
          as_input = 1'b1;
        end
      end
      MODE_COMPLEX: begin
        val      = sum_less;
        drive    = oe_term;
        as_input = io_cfg && !IS_OUTER;
      end
      MODE_SIMPLE: begin
        if (io_cfg && !IS_INNER) begin
          as_input = 1'b1;
        end else begin
          val   = sum_all;
          drive = 1'b1;
        end
      end
      default: begin
        drive = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out  <= 1'b0;
      pin_oe_b <= 1'b1;
      is_input <= 1'b0;
    end else begin
      pin_out  <= polarity ? val : ~val;
      pin_oe_b <= !(run && drive);
      is_input <= run && as_input;
    end
  end

endmodule : output_macrocell

/* File: rtl/output_macrocell_mode_config.sv */
// macrocell array top: apb configuration, special pins, feedback routing
`timescale 1ns/100ps
module output_macrocell_mode_config #(
  parameter int NCELL = ocfg_pkg::NUM_CELLS,
  parameter int NPT   = ocfg_pkg::PT_PER_CELL
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_b,
  input  wire logic [ocfg_pkg::ADDR_W-1:0] paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ocfg_pkg::DATA_W-1:0] pwdata,
  output logic      [ocfg_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [NCELL*NPT-1:0]        pt_in,
  input  wire logic                        spec_clk_pin,
  input  wire logic                        spec_oe_b_pin,
  input  wire logic [NCELL-1:0]            io_in,
  output logic      [NCELL-1:0]            io_out,
  output logic      [NCELL-1:0]            io_oe_b,
  output logic      [NCELL-1:0]            array_fb,
  output logic      [1:0]                  array_spec_in
);
  import ocfg_pkg::*;

  logic             sync_mode_bit_q;
  logic             global_arch_bit_q;
  logic [NCELL-1:0] pol_q;
  logic [NCELL-1:0] cell_io_config_bit_q;
  logic             run_q;
  mode_t            mode;
  logic             clk_pin_q;
  logic             clk_edge;
  logic             shared_oe;
  logic [NCELL-1:0] st_reg_q;
  logic [NCELL-1:0] st_input;
  logic             setup;
  logic             access;
  logic             wr_en;
  logic             addr_ok;
  logic             cfg_addr;
  logic             locked;
  logic [DATA_W-1:0] rd_d;
  logic [NCELL-1:0] fb_d;
  logic [1:0]       spec_d;

  assign mode = decode_mode(sync_mode_bit_q, global_arch_bit_q);

  // apb slave: no wait states, read data latched in the setup cycle
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign pready   = 1'b1;
  assign addr_ok  = paddr == ADDR_MODE || paddr == ADDR_POL || paddr == ADDR_IOCFG ||
                    paddr == ADDR_RUN || paddr == ADDR_STATUS || paddr == ADDR_PINS;
  assign cfg_addr = paddr == ADDR_MODE || paddr == ADDR_POL || paddr == ADDR_IOCFG;
  // a config write while running is refused so the array never sees a glitch
  assign locked   = pwrite && cfg_addr && run_q;
  assign pslverr  = access && (!addr_ok || locked ||
                    (pwrite && (paddr == ADDR_STATUS || paddr == ADDR_PINS)));
  assign wr_en    = access && pwrite && !pslverr;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_mode_bit_q   <= SYNC_RST;
      global_arch_bit_q <= ARCH_RST;
    end else if (wr_en && paddr == ADDR_MODE) begin
      sync_mode_bit_q   <= pwdata[MODE_SYNC_POS];
      global_arch_bit_q <= pwdata[MODE_ARCH_POS];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pol_q <= POL_RST;
    end else if (wr_en && paddr == ADDR_POL) begin
      pol_q <= pwdata[NCELL-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cell_io_config_bit_q <= IOCFG_RST;
    end else if (wr_en && paddr == ADDR_IOCFG) begin
      cell_io_config_bit_q <= pwdata[NCELL-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= RUN_RST;
    end else if (wr_en && paddr == ADDR_RUN) begin
      run_q <= pwdata[RUN_POS];
    end
  end

  always_comb begin
    rd_d = '0;
    case (paddr)
      ADDR_MODE: begin
        rd_d[MODE_SYNC_POS] = sync_mode_bit_q;
        rd_d[MODE_ARCH_POS] = global_arch_bit_q;
        rd_d[MODE_EFF_POS+:2] = mode;
      end
      ADDR_POL: begin
        rd_d[NCELL-1:0] = pol_q;
      end
      ADDR_IOCFG: begin
        rd_d[NCELL-1:0] = cell_io_config_bit_q;
      end
      ADDR_RUN: begin
        rd_d[RUN_POS] = run_q;
      end
      ADDR_STATUS: begin
        rd_d[ST_REG_POS+:NCELL] = st_reg_q;
        rd_d[ST_DRV_POS+:NCELL] = ~io_oe_b;
        rd_d[ST_IN_POS+:NCELL]  = st_input;
        rd_d[ST_MODE_POS+:2]    = mode;
      end
      ADDR_PINS: begin
        rd_d[NCELL-1:0]         = io_in;
        rd_d[PINS_SPEC_POS]     = spec_clk_pin;
        rd_d[PINS_SPEC_POS+1]   = spec_oe_b_pin;
      end
      default: begin
        rd_d = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      prdata <= rd_d;
    end
  end

  // special pins: pins arrive synchronous, so a single history flop finds the rise
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_pin_q <= 1'b0;
    end else begin
      clk_pin_q <= spec_clk_pin;
    end
  end

  assign clk_edge  = (mode == MODE_REG) && spec_clk_pin && !clk_pin_q;
  assign shared_oe = (mode == MODE_REG) && !spec_oe_b_pin;

  for (genvar i = 0; i < NCELL; i++) begin : g_cell
    output_macrocell #(
      .PT_W     (NPT),
      .IS_OUTER (i == OUTER_LO || i == OUTER_HI),
      .IS_INNER (i == INNER_LO || i == INNER_HI)
    ) u_cell (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .mode     (mode),
      .run      (run_q),
      .io_cfg   (cell_io_config_bit_q[i]),
      .polarity (pol_q[i]),
      .pt       (pt_in[i*NPT+:NPT]),
      .clk_edge (clk_edge),
      .shared_oe(shared_oe),
      .pin_out  (io_out[i]),
      .pin_oe_b (io_oe_b[i]),
      .reg_q_o  (st_reg_q[i]),
      .is_input (st_input[i])
    );
  end

  // feedback into the array and special-pin data inputs
  always_comb begin
    fb_d   = '0;
    spec_d = '0;
    case (mode)
      MODE_REG: begin
        for (int i = 0; i < NCELL; i++) begin
          fb_d[i] = cell_io_config_bit_q[i] ? io_in[i] : st_reg_q[i];
        end
        spec_d = '0;
      end
      MODE_COMPLEX: begin
        fb_d          = io_in;
        fb_d[OUTER_LO] = !spec_oe_b_pin;
        fb_d[OUTER_HI] = spec_clk_pin;
        spec_d        = {spec_oe_b_pin, spec_clk_pin};
      end
      MODE_SIMPLE: begin
        fb_d           = io_in;
        fb_d[INNER_LO] = 1'b0;
        fb_d[INNER_HI] = 1'b0;
        spec_d         = {spec_oe_b_pin, spec_clk_pin};
      end
      default: begin
        fb_d   = '0;
        spec_d = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      array_fb      <= '0;
      array_spec_in <= '0;
    end else begin
      array_fb      <= fb_d;
      array_spec_in <= spec_d;
    end
  end

  // checks on the cells and routing
  logic sum1;
  logic sum2;
  logic sum4_less;
  logic oe2;
  assign sum1      = |pt_in[1*NPT+:NPT];
  assign sum2      = |pt_in[2*NPT+:NPT];
  assign sum4_less = |pt_in[4*NPT+1+:NPT-1];
  assign oe2       = pt_in[2*NPT+OE_TERM_IDX];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_mode_bad_quiet: assert property (
    mode == MODE_BAD |=> &io_oe_b)
    else $error("cells driven in undefined mode");

  a_reg_no_spec: assert property (
    mode == MODE_REG |=> array_spec_in == 2'b00)
    else $error("special pins reach array in registered mode");

  a_reg_shared_oe: assert property (
    mode == MODE_REG && run_q && !cell_io_config_bit_q[1] && spec_oe_b_pin |=> io_oe_b[1])
    else $error("registered output driven with shared enable off");

  a_reg_capture: assert property (
    mode == MODE_REG && run_q && !cell_io_config_bit_q[2] && clk_edge
    |=> st_reg_q[2] == $past(sum2))
    else $error("register did not take its sum on clock rise");

  a_reg_hold: assert property (
    !clk_edge && $stable(run_q) |=> $stable(st_reg_q))
    else $error("register moved without clock pin rise");

  a_io_seven_terms: assert property (
    mode == MODE_REG && run_q && cell_io_config_bit_q[4] && pol_q[4]
    |=> io_out[4] == $past(sum4_less))
    else $error("io cell did not sum seven terms");

  a_complex_outer_fb: assert property (
    mode == MODE_COMPLEX |=> array_fb[OUTER_HI] == $past(spec_clk_pin))
    else $error("outer feedback not carrying special pin");

  a_complex_oe_term: assert property (
    mode == MODE_COMPLEX && run_q ##0 oe2 == 1'b0 |=> io_oe_b[2])
    else $error("complex cell driven with enable term low");

  a_outer_no_input: assert property (
    mode == MODE_COMPLEX |=> !st_input[OUTER_LO] && !st_input[OUTER_HI])
    else $error("outer cell used as input in complex mode");

  a_simple_inner_on: assert property (
    mode == MODE_SIMPLE && run_q |=> !io_oe_b[INNER_LO] && !io_oe_b[INNER_HI])
    else $error("inner cell not driven in simple mode");

  a_simple_input_off: assert property (
    mode == MODE_SIMPLE && run_q && cell_io_config_bit_q[0] |=> io_oe_b[0])
    else $error("simple input cell is driving");

  a_polarity_low: assert property (
    mode == MODE_SIMPLE && run_q && !cell_io_config_bit_q[1] && !pol_q[1]
    |=> io_out[1] == !$past(sum1))
    else $error("active low polarity wrong");

  a_cfg_locked: assert property (
    access && pwrite && paddr == ADDR_POL && run_q |=> $stable(pol_q))
    else $error("configuration changed while running");

  c_reg_run: cover property (mode == MODE_REG && run_q && clk_edge);
  c_complex_run: cover property (mode == MODE_COMPLEX && run_q ##1 !io_oe_b[2]);
  c_simple_run: cover property (mode == MODE_SIMPLE && run_q ##1 !io_oe_b[1]);
  c_locked_write: cover property (access && locked);

endmodule : output_macrocell_mode_config

/* File: test/board_model.sv */
// board logic around the cell pins: drives every pin that the array releases
`timescale 1ns/100ps
module board_model (
  input  wire logic [7:0] io_out,
  input  wire logic [7:0] io_oe_b,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] io_in
);
  // a released pin shows the board's own value, never the last driven one
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      io_in[i] = io_oe_b[i] ? ext_val[i] : io_out[i];
    end
  end
endmodule : board_model

/* File: test/tb.sv */
// testbench: apb configuration and pin behaviour of the macrocell array
`timescale 1ns/100ps
module tb;
  import ocfg_pkg::*;
  localparam logic [63:0] PAT = 64'h01fe_0080_7f00_02ff;
  // mode codes per pass, lowest byte first: simple, complex, registered, undefined
  localparam logic [31:0] MCODE = 32'h0002_0301;
  logic        ref_clk;
  logic        rst_b;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [63:0] pt_in;
  logic        ck;
  logic        oeb;
  logic [7:0]  ext_val;
  logic [7:0]  io_in;
  logic [7:0]  io_out;
  logic [7:0]  io_oe_b;
  logic [7:0]  array_fb;
  logic [1:0]  array_spec_in;
  logic        s_m;
  logic        a_m;
  logic        run_m;
  logic [7:0]  pol_m;
  logic [7:0]  cfg_m;
  logic [7:0]  rg_m;
  logic [7:0]  drv_m;
  logic [7:0]  in_m;
  logic [7:0]  pin_m;
  logic [31:0] r_v;
  logic        e_v;
  int          bad_count;
  int          compares;

  output_macrocell_mode_config i_output_macrocell_mode_config (
    .ref_clk(ref_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pt_in(pt_in), .spec_clk_pin(ck), .spec_oe_b_pin(oeb), .io_in(io_in), .io_out(io_out),
    .io_oe_b(io_oe_b), .array_fb(array_fb), .array_spec_in(array_spec_in));
  board_model i_board_model (.io_out(io_out), .io_oe_b(io_oe_b), .ext_val(ext_val),
    .io_in(io_in));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task wrap_up;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // holds the request until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // only the watchdog ends a wait that never gets an answer
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdc(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    apb(1'b0, a, 32'h0, r_v, e_v);
    chk(r_v, exp);
    chk(32'(e_v), 32'(ee));
  endtask : rdc

  task wrc(input logic [11:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d, r_v, e_v);
    chk(32'(e_v), 32'(ee));
  endtask : wrc

  task setup(input logic [7:0] m, input logic [7:0] c, input logic [7:0] p);
    wrc(ADDR_RUN, 32'h0, 1'b0);
    wrc(ADDR_MODE, 32'(m), 1'b0);
    wrc(ADDR_POL, 32'(p), 1'b0);
    wrc(ADDR_IOCFG, 32'(c), 1'b0);
    wrc(ADDR_RUN, 32'h1, 1'b0);
    s_m   = m[0];
    a_m   = m[1];
    pol_m = p;
    cfg_m = c;
    run_m = 1'b1;
  endtask : setup

  function automatic logic [1:0] eff(input logic s, input logic a);
    eff = s ? (a ? 2'b01 : 2'b10) : (a ? 2'b00 : 2'b11);
  endfunction : eff

  // expected pins worked out per cell from mode, config and board drive
  task pins;
    logic [7:0] o;
    logic [7:0] pin;
    logic [7:0] fb;
    logic       v;
    logic       d;
    repeat (4) @(posedge ref_clk);
    #1;
    for (int i = 0; i < 8; i++) begin
      v = |pt_in[i*8+1 +: 7];
      d = pt_in[i*8];
      if (s_m && !a_m) begin
        d = !(cfg_m[i] && i != INNER_LO && i != INNER_HI);
        v = |pt_in[i*8 +: 8];
      end else if (!s_m && a_m && !cfg_m[i]) begin
        d = !oeb;
        v = rg_m[i];
      end else if (!s_m && !a_m) begin
        d = 1'b0;
        v = 1'b0;
      end
      drv_m[i] = d && run_m;
      in_m[i]  = run_m && cfg_m[i] && (s_m || a_m) &&
                 !(s_m && !a_m && (i == INNER_LO || i == INNER_HI)) &&
                 !(s_m && a_m && (i == OUTER_LO || i == OUTER_HI));
      o[i]     = pol_m[i] ? v : !v;
      pin[i]   = drv_m[i] ? o[i] : ext_val[i];
      fb[i]    = pin[i];
      if (!s_m && a_m && !cfg_m[i]) fb[i] = rg_m[i];
      if (s_m && a_m && i == OUTER_LO) fb[i] = !oeb;
      if (s_m && a_m && i == OUTER_HI) fb[i] = ck;
      if (s_m && !a_m && (i == INNER_LO || i == INNER_HI)) fb[i] = 1'b0;
      if (!s_m && !a_m) fb[i] = 1'b0;
    end
    chk(32'(io_oe_b), {24'h0, ~drv_m});
    chk(32'(io_out & drv_m), 32'(o & drv_m));
    if (run_m) chk(32'(array_fb), 32'(fb));
    chk(32'(array_spec_in), s_m ? {30'h0, oeb, ck} : 32'h0);
    pin_m = pin;
  endtask : pins

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    wrap_up;
  end

  initial begin
    rst_b   = 1'b0;
    paddr   = 12'h000;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0;
    pt_in   = 64'h0;
    ck      = 1'b0;
    oeb     = 1'b0;
    ext_val = 8'h3c;
    s_m     = 1'b1;
    a_m     = 1'b0;
    run_m   = 1'b0;
    pol_m   = 8'h00;
    cfg_m   = 8'hff;
    rg_m    = 8'h00;
    drv_m   = 8'h00;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdc(ADDR_MODE, 32'h21, 1'b0);
    rdc(ADDR_POL, 32'h0, 1'b0);
    rdc(ADDR_IOCFG, 32'hff, 1'b0);
    rdc(ADDR_RUN, 32'h0, 1'b0);
    rdc(12'h0f0, 32'h0, 1'b1);
    wrc(ADDR_STATUS, 32'h1, 1'b1);
    pins();
    for (int j = 0; j < 4; j++) begin
      // registered and undefined modes get the other pattern so active-low outputs are seen in registered mode too; undefined mode drives no cell
      setup(MCODE[8*j +: 8], 8'h99, j[1] ? 8'h5a : 8'ha5);
      wrc(ADDR_MODE, 32'h0, 1'b1);
      wrc(ADDR_POL, 32'hff, 1'b1);
      rdc(ADDR_POL, 32'(pol_m), 1'b0);
      rdc(ADDR_IOCFG, 32'h99, 1'b0);
      rdc(ADDR_MODE, {26'h0, eff(s_m, a_m), 2'b00, a_m, s_m}, 1'b0);
      for (int k = 0; k < 2; k++) begin
        @(posedge ref_clk);
        pt_in   <= k[0] ? ~PAT : PAT;
        ext_val <= k[0] ? 8'hc3 : 8'h3c;
        oeb     <= k[0];
        ck      <= 1'b0;
        repeat (3) @(posedge ref_clk);
        // registered and undefined modes get a clock rise, simple and complex modes see a data level
        ck <= s_m ? k[0] : 1'b1;
        if (!s_m && a_m) begin
          for (int i = 0; i < 8; i++) begin
            if (!cfg_m[i]) rg_m[i] = |pt_in[i*8 +: 8];
          end
        end
        pins();
        apb(1'b0, ADDR_STATUS, 32'h0, r_v, e_v);
        chk(r_v & 32'h03ffff00, {6'h0, eff(s_m, a_m), in_m, drv_m, 8'h0});
        rdc(ADDR_PINS, {22'h0, oeb, ck, pin_m}, 1'b0);
      end
    end
    wrap_up;
  end
endmodule : tb
